// ### bench/adsio_chk_sva.sv
// Assertions on bus answer, PCM framing, core divider and pulses.
// Assumes a bind to adsio_top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module adsio_chk (
    input wire logic CLK,
    input wire logic RST,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic STREAM_VALID,
    input wire logic [1:0] CORE_LOAD,
    input wire logic [1:0] CORE_CLK_DIV,
    input wire logic DECODE_EN,
    input wire logic SAMPLE_VALID,
    input wire logic SAMPLE_READY,
    input wire logic PCM_SERIAL_OUT,
    input wire logic PCM_BIT_CLOCK,
    input wire logic PCM_WORD_CLOCK,
    input wire logic PLL_UPDATE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    sequence s_answer;
        !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endsequence
    sequence s_quiet;
        !STREAM_VALID [*8];
    endsequence
    AST_BUS_ANSWER: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> s_answer)
        else $error("bus answer not one cycle after request");
    AST_NO_OWN_ANSWER: assert property (!AVS_WAITREQUEST |-> $past(AVS_READ || AVS_WRITE))
        else $error("answer without request");
    AST_RDATA_IDLE: assert property (AVS_WAITREQUEST |-> AVS_READDATA == 32'h0000_0000)
        else $error("read data outside answer");
    AST_CORE_DIV: assert property (1'b1 |=> CORE_CLK_DIV == 2'h3 - $past(CORE_LOAD))
        else $error("core divider does not follow load");
    AST_DATA_GATED: assert property (!DECODE_EN && !$past(DECODE_EN) |-> !PCM_SERIAL_OUT)
        else $error("data while not decoding");
    AST_WORD_EDGE: assert property ($changed(PCM_WORD_CLOCK) |-> !PCM_BIT_CLOCK)
        else $error("word clock moved with bit clock high");
    AST_BYTE_PULSE: assert property (STREAM_VALID |=> s_quiet)
        else $error("byte strobe too long");
    AST_READY_DROP: assert property (SAMPLE_VALID && SAMPLE_READY |=> !SAMPLE_READY)
        else $error("ready held after accept");
    AST_UPDATE: assert property (PLL_UPDATE |-> DECODE_EN ##1 !PLL_UPDATE)
        else $error("fraction update outside decode");
endmodule
`default_nettype wire

// ### bench/adsio_src.sv
// Channel decoder model: serial bitstream and reference pulses.
// Assumes the bench calls its tasks; clock idles low, gate pulled high.
`timescale 1ns/1ps
`default_nettype none
module adsio_src (
    input wire logic clk,
    output var logic ser_in,
    output var logic bit_clk,
    output var logic gate,
    output var logic ref_pulse
);
    initial begin
        ser_in = 1'b0;
        bit_clk = 1'b0;
        gate = 1'b1;
        ref_pulse = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Leading n bits of v with gate level g
    task automatic send(input logic [7:0] v, input int n, input logic g);
        int i;
        for (i = 7; i > 7 - n; i--) begin
            tick(4);
            ser_in <= v[i];
            gate <= g;
            tick(4);
            bit_clk <= 1'b1;
            tick(8);
            bit_clk <= 1'b0;
            tick(4);
            ser_in <= ~v[i];
            gate <= 1'b1;
        end
    endtask
    task automatic pulse;
        ref_pulse <= 1'b1;
        tick(8);
        ref_pulse <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Bench for adsio_top: register, stream, PCM and state tests.
// Assumes the channel decoder model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "adsio_consts.vh"
module tb_top;
    logic clk, rst, rd, wr, sv, si, sc, ga, rp, val, ref_sel, den, srdy, pd, pb, pw, osc, upd;
    logic wreq, oscq, pwq;
    logic [3:0] rps = 4'h0;
    logic [15:0] nlast;
    logic [7:0] ad, sb, lb;
    logic [31:0] wd, rdata, r;
    logic [1:0] load, cdiv;
    logic [23:0] sl, sr;
    logic [2:0] md [3] = '{3'h7, 3'h1, 3'h5};
    logic [2:0] mr = 3'h5;
    int n_fail = 0, n_compared = 0, nb = 0, nu = 0, nosc = 0, nw = 0, i, k, t, o;
    adsio_top i_adsio_top (.CLK(clk), .RST(rst), .AVS_ADDRESS(ad), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wd), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .STREAM_SERIAL_IN(si),
        .STREAM_BIT_CLOCK(sc), .BIT_GATE(ga), .RATE_REF_PULSE(rp), .STREAM_BYTE(sb), .STREAM_VALID(val),
        .CORE_LOAD(load), .CORE_CLK_DIV(cdiv), .REF_SELECT(ref_sel), .DECODE_EN(den), .SAMPLE_LEFT(sl),
        .SAMPLE_RIGHT(sr), .SAMPLE_VALID(sv), .SAMPLE_READY(srdy), .PCM_SERIAL_OUT(pd),
        .PCM_BIT_CLOCK(pb), .PCM_WORD_CLOCK(pw), .DAC_OVERSAMPLE_CLOCK(osc), .PLL_UPDATE(upd));
    adsio_src i_adsio_src (.clk(clk), .ser_in(si), .bit_clk(sc), .gate(ga), .ref_pulse(rp));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (val === 1'b1) begin
            nb <= nb + 1;
            lb <= sb;
        end
        if (upd === 1'b1) begin
            nu <= nu + 1;
        end
        oscq <= osc;
        if (osc !== oscq) begin
            nosc <= nosc + 1;
        end
        // Left word starts between synchronised reference edges
        pwq <= pw;
        rps <= {rps[2:0], rp};
        if (rps[2] && !rps[3]) begin
            nlast <= nw[15:0];
            nw <= 0;
        end else if (pwq === 1'b1 && pw === 1'b0) begin
            nw <= nw + 1;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int c;
        c = 0;
        @(posedge clk);
        ad <= a;
        wd <= d;
        rd <= ~w;
        wr <= w;
        do begin
            @(posedge clk);
            c++;
        end while (wreq !== 1'b0 && c < 50);
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        chk({31'h0, wreq}, 32'h0);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(r, e);
    endtask
    task automatic watch(output int tg, output int on);
        logic p;
        tg = 0;
        on = 0;
        p = pb;
        repeat (200) begin
            @(posedge clk);
            tg += (pb !== p);
            on += (pd !== 1'b0);
            p = pb;
        end
    endtask
    task automatic cap(output logic [31:0] w);
        logic p;
        int c, j;
        c = 0;
        j = 0;
        while (pw !== 1'b1 && c < 4000) begin
            @(posedge clk);
            c++;
        end
        while (pw !== 1'b0 && c < 4000) begin
            @(posedge clk);
            c++;
        end
        p = pb;
        while (j < 32 && c < 4000) begin
            @(posedge clk);
            c++;
            if (pb === 1'b1 && p === 1'b0) begin
                w = {w[30:0], pd};
                j++;
            end
            p = pb;
        end
    endtask
    function automatic logic [31:0] expw(input logic [23:0] s, input int wl, input logic lsb);
        logic [31:0] e;
        int j;
        e = 32'h0000_0000;
        for (j = 0; j < wl; j++) begin
            e[31 - j] = lsb ? s[24 - wl + j] : s[23 - j];
        end
        return e;
    endfunction
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        final_report();
    end
    initial begin
        {rd, wr, sv, ad, wd, load} = '0;
        rst = 1'b1;
        sl = 24'hC3_5A96;
        sr = 24'h1E_8F01;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdc(`ADSIO_OFF_CTRL, `ADSIO_RST_CTRL);
        rdc(`ADSIO_OFF_PCM_FMT, `ADSIO_RST_FMT);
        rdc(`ADSIO_OFF_PCM_DIV, `ADSIO_RST_DIV);
        rdc(`ADSIO_OFF_PLL_FRAC, `ADSIO_RST_FRAC);
        rdc(`ADSIO_OFF_STATUS, 32'h0);
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        rdc(8'h20, 32'h0);
        for (i = 0; i < 6; i++) begin
            bus(1'b1, `ADSIO_OFF_PCM_FMT, 32'(i * 8 + 3));
            rdc(`ADSIO_OFF_PCM_FMT, 32'(i * 8 + 3));
        end
        bus(1'b1, `ADSIO_OFF_CTRL, 32'h12);
        repeat (2) @(posedge clk);
        chk(ref_sel, 1'b1);
        for (i = 0; i < 4; i++) begin
            load <= i[1:0];
            repeat (3) @(posedge clk);
            chk(cdiv, 32'(3 - i));
        end
        $display("registers and clocks test done");
        bus(1'b1, `ADSIO_OFF_CTRL, 32'h02);
        i_adsio_src.send(8'hA5, 8, 1'b1);
        repeat (8) @(posedge clk);
        chk(lb, 8'hA5);
        i_adsio_src.send(8'hF0, 4, 1'b0);
        i_adsio_src.send(8'h3C, 8, 1'b1);
        repeat (8) @(posedge clk);
        chk(lb, 8'h3C);
        bus(1'b1, `ADSIO_OFF_CTRL, 32'h0A);
        i_adsio_src.send(8'h96, 8, 1'b1);
        repeat (8) @(posedge clk);
        chk(lb, 8'h96);
        chk(nb, 3);
        $display("stream test done");
        bus(1'b1, `ADSIO_OFF_PLL_FRAC, 32'hFFF0);
        bus(1'b1, `ADSIO_OFF_CTRL, 32'h02);
        k = nosc;
        watch(t, o);
        chk(t, 0);
        chk(nosc - k, 0);
        bus(1'b1, `ADSIO_OFF_CTRL, 32'h06);
        k = nosc;
        watch(t, o);
        chk(t != 0, 1'b1);
        chk(nosc != k, 1'b1);
        chk(o, 0);
        bus(1'b1, `ADSIO_OFF_CTRL, 32'h07);
        repeat (2) @(posedge clk);
        rdc(`ADSIO_OFF_STATUS, 32'h9);
        bus(1'b1, `ADSIO_OFF_CTRL, 32'h03);
        watch(t, o);
        chk(t != 0, 1'b1);
        chk(o, 0);
        sv <= 1'b1;
        k = 0;
        do begin
            bus(1'b0, `ADSIO_OFF_STATUS, 32'h0);
            k++;
        end while (r[1:0] !== 2'h2 && k < 40);
        chk(r[3:0], 4'hA);
        for (i = 0; i < 8; i++) begin
            bus(1'b1, `ADSIO_OFF_PCM_FMT, 32'(i));
            cap(r);
            cap(r);
            chk(r, expw(sl, (i % 4 == 3) ? 24 : 16 + 2 * (i % 4), i / 4));
        end
        $display("state and format test done");
        i_adsio_src.pulse();
        repeat (2000) @(posedge clk);
        i_adsio_src.pulse();
        repeat (20) @(posedge clk);
        rdc(`ADSIO_OFF_PLL_FRAC, 32'hFFF2);
        chk(nu, 2);
        bus(1'b0, `ADSIO_OFF_STATUS, 32'h0);
        chk(r[2], 1'b1);
        for (i = 0; i < 3; i++) begin
            bus(1'b1, `ADSIO_OFF_CTRL, {29'h0, md[i]});
            repeat (20) @(posedge clk);
            watch(t, o);
            chk(t != 0, mr[i]);
            chk(o, 0);
            chk(den, i == 0);
        end
        bus(1'b1, `ADSIO_OFF_CTRL, 32'h00);
        rdc(`ADSIO_OFF_STATUS, {nlast, 16'h0004});
        $display("compensation and mode test done");
        final_report();
    end
endmodule
bind adsio_top adsio_chk i_adsio_chk (.CLK(CLK), .RST(RST), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .STREAM_VALID(STREAM_VALID),
    .CORE_LOAD(CORE_LOAD), .CORE_CLK_DIV(CORE_CLK_DIV), .DECODE_EN(DECODE_EN), .SAMPLE_VALID(SAMPLE_VALID),
    .SAMPLE_READY(SAMPLE_READY), .PCM_SERIAL_OUT(PCM_SERIAL_OUT), .PCM_BIT_CLOCK(PCM_BIT_CLOCK),
    .PCM_WORD_CLOCK(PCM_WORD_CLOCK), .PLL_UPDATE(PLL_UPDATE));
`default_nettype wire

// ### common/adsio_consts.vh
// Constants of the audio decoder stream and control shell.
// Assumes inclusion by bare name from the design file.
`ifndef ADSIO_CONSTS_VH
`define ADSIO_CONSTS_VH

// Register byte offsets
`define ADSIO_OFF_CTRL 8'h00
`define ADSIO_OFF_PCM_FMT 8'h04
`define ADSIO_OFF_PCM_DIV 8'h08
`define ADSIO_OFF_PLL_FRAC 8'h0C
`define ADSIO_OFF_STATUS 8'h10

// Control fields
`define ADSIO_CTRL_RUN 0
`define ADSIO_CTRL_DECODE_RUN_FLAG 1
`define ADSIO_CTRL_MUTE 2
`define ADSIO_CTRL_FALL 3
`define ADSIO_CTRL_REFSEL 4

// Format fields
`define ADSIO_FMT_WL_LO 0
`define ADSIO_FMT_WL_HI 1
`define ADSIO_FMT_LSB 2
`define ADSIO_FMT_RATE_LO 3
`define ADSIO_FMT_RATE_HI 5

// Status fields
`define ADSIO_STAT_REF 2
`define ADSIO_STAT_DEC 3

// Reset values
`define ADSIO_RST_CTRL 5'h02
`define ADSIO_RST_FMT 6'h03
`define ADSIO_RST_DIV 8'h01
`define ADSIO_RST_FRAC 16'h59C8

// Decoder states
`define ADSIO_ST_IDLE 2'h0
`define ADSIO_ST_INIT 2'h1
`define ADSIO_ST_DEC 2'h2

// Word lengths in bits and last slot index
`define ADSIO_WL16 5'h10
`define ADSIO_WL18 5'h12
`define ADSIO_WL20 5'h14
`define ADSIO_WL24 5'h18
`define ADSIO_SLOT_LAST 5'h1F

// Samples per 432 ms reference period for each rate
`define ADSIO_EXP_48K 16'h5100
`define ADSIO_EXP_32K 16'h3600
`define ADSIO_EXP_24K 16'h2880
`define ADSIO_EXP_16K 16'h1B00
`define ADSIO_EXP_12K 16'h1440
`define ADSIO_EXP_8K 16'h0D80

// Fraction correction step
`define ADSIO_FRAC_STEP 16'h0001

`endif

// ### src/adsio_top.v
// Bitstream input, clock generation, rate compensation, PCM output and state control.
// Assumes one 250 MHz clock, synchronous reset, Avalon-MM master, decoder core on CLK.
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`include "adsio_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module adsio_top (
    input wire CLK,
    input wire RST,
    input wire [7:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    output reg [31:0] AVS_READDATA,
    output reg AVS_WAITREQUEST,
    input wire STREAM_SERIAL_IN,
    input wire STREAM_BIT_CLOCK,
    input wire BIT_GATE,
    input wire RATE_REF_PULSE,
    output reg [7:0] STREAM_BYTE,
    output reg STREAM_VALID,
    input wire [1:0] CORE_LOAD,
    output reg [1:0] CORE_CLK_DIV,
    output reg REF_SELECT,
    output reg DECODE_EN,
    input wire [23:0] SAMPLE_LEFT,
    input wire [23:0] SAMPLE_RIGHT,
    input wire SAMPLE_VALID,
    output reg SAMPLE_READY,
    output reg PCM_SERIAL_OUT,
    output reg PCM_BIT_CLOCK,
    output reg PCM_WORD_CLOCK,
    output reg DAC_OVERSAMPLE_CLOCK,
    output reg PLL_UPDATE
);

    // Pin synchronisers
    reg [1:0] sdi_s_q, sck_s_q, gate_s_q, ref_s_q;
    reg sck_d1_q, ref_d1_q;

    // Registers
    reg [4:0] ctrl_q;
    reg [5:0] fmt_q;
    reg [7:0] div_q;
    reg [15:0] pll_fraction_setting_q;
    reg ref_seen_q;
    reg [15:0] last_cnt_q;

    // State
    reg [1:0] state_q;
    reg decode_run_flag_eff_q, mute_eff_q;

    // Input shifter
    reg [7:0] sh_q;
    reg [2:0] nbit_q;

    // Clock generation
    reg [16:0] acc_q;
    reg [7:0] div_cnt_q;
    reg [4:0] slot_q;
    reg first_q;

    // Output path
    reg [23:0] hold_l_q, hold_r_q, word_l_q, word_r_q;
    reg hold_full_q;
    reg [15:0] samp_cnt_q;

    wire bus_req = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST;
    wire bus_done = (AVS_READ | AVS_WRITE) & ~AVS_WAITREQUEST;
    wire wr = AVS_WRITE & ~AVS_WAITREQUEST;

    wire sck_rise = sck_s_q[1] & ~sck_d1_q;
    wire sck_fall = ~sck_s_q[1] & sck_d1_q;
    wire cap_edge = ctrl_q[`ADSIO_CTRL_FALL] ? sck_fall : sck_rise;
    wire ref_event = ref_s_q[1] & ~ref_d1_q;

    // Clock run condition per state
    reg clk_run;
    always @* begin
        case (state_q)
            `ADSIO_ST_IDLE: clk_run = ctrl_q[`ADSIO_CTRL_MUTE];
            `ADSIO_ST_INIT: clk_run = mute_eff_q;
            `ADSIO_ST_DEC: clk_run = decode_run_flag_eff_q | mute_eff_q;
            default: clk_run = 1'b0;
        endcase
    end

    wire data_on = (state_q == `ADSIO_ST_DEC) & decode_run_flag_eff_q & ~mute_eff_q;
    wire comp_on = (state_q == `ADSIO_ST_DEC) & decode_run_flag_eff_q;

    reg [4:0] wl;
    always @* begin
        case (fmt_q[`ADSIO_FMT_WL_HI:`ADSIO_FMT_WL_LO])
            2'h0: wl = `ADSIO_WL16;
            2'h1: wl = `ADSIO_WL18;
            2'h2: wl = `ADSIO_WL20;
            default: wl = `ADSIO_WL24;
        endcase
    end

    reg [15:0] expect_cnt;
    always @* begin
        case (fmt_q[`ADSIO_FMT_RATE_HI:`ADSIO_FMT_RATE_LO])
            3'h0: expect_cnt = `ADSIO_EXP_48K;
            3'h1: expect_cnt = `ADSIO_EXP_32K;
            3'h2: expect_cnt = `ADSIO_EXP_24K;
            3'h3: expect_cnt = `ADSIO_EXP_16K;
            3'h4: expect_cnt = `ADSIO_EXP_12K;
            default: expect_cnt = `ADSIO_EXP_8K;
        endcase
    end

    // Oscillator and dividers
    wire [16:0] acc_sum = {1'b0, acc_q[15:0]} + {1'b0, pll_fraction_setting_q};
    wire os_tick = clk_run & acc_sum[16];
    wire bclk_tog = os_tick & (div_cnt_q == 8'h00);
    wire bclk_fall = bclk_tog & PCM_BIT_CLOCK;
    wire [4:0] slot_n = first_q ? 5'h00 : slot_q + 5'h01;
    wire new_word = bclk_fall & (first_q | (slot_q == `ADSIO_SLOT_LAST));
    wire lr_n = first_q ? 1'b0 : (new_word ? ~PCM_WORD_CLOCK : PCM_WORD_CLOCK);
    wire left_start = new_word & ~lr_n;
    wire [23:0] cur_word = lr_n ? word_r_q : word_l_q;
    wire [4:0] idx = fmt_q[`ADSIO_FMT_LSB] ? 5'h18 - wl + slot_n : 5'h17 - slot_n;
    wire accept = SAMPLE_VALID & SAMPLE_READY & (state_q != `ADSIO_ST_IDLE);

    always @(posedge CLK) begin
        if (RST) begin
            sdi_s_q <= 2'h0;
            sck_s_q <= 2'h0;
            gate_s_q <= 2'h0;
            ref_s_q <= 2'h0;
            sck_d1_q <= 1'b0;
            ref_d1_q <= 1'b0;
        end else begin
            sdi_s_q <= {sdi_s_q[0], STREAM_SERIAL_IN};
            sck_s_q <= {sck_s_q[0], STREAM_BIT_CLOCK};
            gate_s_q <= {gate_s_q[0], BIT_GATE};
            ref_s_q <= {ref_s_q[0], RATE_REF_PULSE};
            sck_d1_q <= sck_s_q[1];
            ref_d1_q <= ref_s_q[1];
        end
    end

    // Register slave
    always @(posedge CLK) begin
        if (RST) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h0000_0000;
            ctrl_q <= `ADSIO_RST_CTRL;
            fmt_q <= `ADSIO_RST_FMT;
            div_q <= `ADSIO_RST_DIV;
            REF_SELECT <= 1'b0;
        end else begin
            AVS_WAITREQUEST <= ~bus_req;
            if (bus_req) begin
                case (AVS_ADDRESS)
                    `ADSIO_OFF_CTRL: AVS_READDATA <= {27'h000_0000, ctrl_q};
                    `ADSIO_OFF_PCM_FMT: AVS_READDATA <= {26'h000_0000, fmt_q};
                    `ADSIO_OFF_PCM_DIV: AVS_READDATA <= {24'h00_0000, div_q};
                    `ADSIO_OFF_PLL_FRAC: AVS_READDATA <= {16'h0000, pll_fraction_setting_q};
                    `ADSIO_OFF_STATUS: AVS_READDATA <= {last_cnt_q, 12'h000, DECODE_EN, ref_seen_q, state_q};
                    default: AVS_READDATA <= 32'h0000_0000;
                endcase
            end else if (bus_done) begin
                AVS_READDATA <= 32'h0000_0000;
            end
            if (wr) begin
                case (AVS_ADDRESS)
                    `ADSIO_OFF_CTRL: ctrl_q <= AVS_WRITEDATA[4:0];
                    `ADSIO_OFF_PCM_FMT: fmt_q <= AVS_WRITEDATA[5:0];
                    `ADSIO_OFF_PCM_DIV: div_q <= AVS_WRITEDATA[7:0];
                    default: ;
                endcase
            end
            REF_SELECT <= ctrl_q[`ADSIO_CTRL_REFSEL];
        end
    end

    // Decoder states
    always @(posedge CLK) begin
        if (RST) begin
            state_q <= `ADSIO_ST_IDLE;
            decode_run_flag_eff_q <= 1'b0;
            mute_eff_q <= 1'b0;
            DECODE_EN <= 1'b0;
        end else begin
            case (state_q)
                `ADSIO_ST_IDLE: begin
                    decode_run_flag_eff_q <= ctrl_q[`ADSIO_CTRL_DECODE_RUN_FLAG];
                    mute_eff_q <= ctrl_q[`ADSIO_CTRL_MUTE];
                    if (ctrl_q[`ADSIO_CTRL_RUN])
                        state_q <= `ADSIO_ST_INIT;
                end
                `ADSIO_ST_INIT: begin
                    if (!ctrl_q[`ADSIO_CTRL_RUN]) begin
                        state_q <= `ADSIO_ST_IDLE;
                    end else if (accept) begin
                        state_q <= `ADSIO_ST_DEC;
                        decode_run_flag_eff_q <= ctrl_q[`ADSIO_CTRL_DECODE_RUN_FLAG];
                        mute_eff_q <= ctrl_q[`ADSIO_CTRL_MUTE];
                    end
                end
                `ADSIO_ST_DEC: begin
                    decode_run_flag_eff_q <= ctrl_q[`ADSIO_CTRL_DECODE_RUN_FLAG];
                    mute_eff_q <= ctrl_q[`ADSIO_CTRL_MUTE];
                    if (!ctrl_q[`ADSIO_CTRL_RUN])
                        state_q <= `ADSIO_ST_IDLE;
                end
                default: state_q <= `ADSIO_ST_IDLE;
            endcase
            DECODE_EN <= (state_q == `ADSIO_ST_INIT) | comp_on;
        end
    end

    // Bitstream capture
    always @(posedge CLK) begin
        if (RST) begin
            sh_q <= 8'h00;
            nbit_q <= 3'h0;
            STREAM_BYTE <= 8'h00;
            STREAM_VALID <= 1'b0;
        end else begin
            STREAM_VALID <= 1'b0;
            if (cap_edge & gate_s_q[1]) begin
                sh_q <= {sh_q[6:0], sdi_s_q[1]};
                nbit_q <= nbit_q + 3'h1;
                if (nbit_q == 3'h7) begin
                    STREAM_BYTE <= {sh_q[6:0], sdi_s_q[1]};
                    STREAM_VALID <= 1'b1;
                end
            end
        end
    end

    // Core clock follows load
    always @(posedge CLK) begin
        if (RST)
            CORE_CLK_DIV <= 2'h3;
        else
            CORE_CLK_DIV <= 2'h3 - CORE_LOAD;
    end

    // PCM clocks and serial data
    always @(posedge CLK) begin
        if (RST || !clk_run) begin
            acc_q <= 17'h0_0000;
            div_cnt_q <= 8'h00;
            slot_q <= 5'h00;
            first_q <= 1'b1;
            PCM_BIT_CLOCK <= 1'b0;
            PCM_WORD_CLOCK <= 1'b0;
            DAC_OVERSAMPLE_CLOCK <= 1'b0;
            PCM_SERIAL_OUT <= 1'b0;
        end else begin
            acc_q <= acc_sum;
            if (os_tick) begin
                DAC_OVERSAMPLE_CLOCK <= ~DAC_OVERSAMPLE_CLOCK;
                div_cnt_q <= (div_cnt_q == 8'h00) ? div_q - 8'h01 : div_cnt_q - 8'h01;
            end
            if (bclk_tog)
                PCM_BIT_CLOCK <= ~PCM_BIT_CLOCK;
            if (bclk_fall) begin
                first_q <= 1'b0;
                slot_q <= slot_n;
                PCM_WORD_CLOCK <= lr_n;
                PCM_SERIAL_OUT <= data_on & (slot_n < wl) & cur_word[idx];
            end
            if (!data_on)
                PCM_SERIAL_OUT <= 1'b0;
        end
    end

    // Sample hold and word latch
    always @(posedge CLK) begin
        if (RST) begin
            hold_l_q <= 24'h00_0000;
            hold_r_q <= 24'h00_0000;
            word_l_q <= 24'h00_0000;
            word_r_q <= 24'h00_0000;
            hold_full_q <= 1'b0;
            SAMPLE_READY <= 1'b0;
        end else begin
            if (left_start) begin
                word_l_q <= hold_l_q;
                word_r_q <= hold_r_q;
            end
            if (accept) begin
                hold_l_q <= SAMPLE_LEFT;
                hold_r_q <= SAMPLE_RIGHT;
                hold_full_q <= 1'b1;
                SAMPLE_READY <= 1'b0;
            end else if (left_start | (state_q == `ADSIO_ST_INIT & ~hold_full_q)) begin
                hold_full_q <= 1'b0;
                SAMPLE_READY <= state_q != `ADSIO_ST_IDLE;
            end else begin
                SAMPLE_READY <= ~hold_full_q & (state_q != `ADSIO_ST_IDLE);
            end
        end
    end

    // Sampling-rate compensation
    always @(posedge CLK) begin
        if (RST) begin
            pll_fraction_setting_q <= `ADSIO_RST_FRAC;
            samp_cnt_q <= 16'h0000;
            last_cnt_q <= 16'h0000;
            ref_seen_q <= 1'b0;
            PLL_UPDATE <= 1'b0;
        end else begin
            PLL_UPDATE <= 1'b0;
            if (ref_event) begin
                ref_seen_q <= 1'b1;
                last_cnt_q <= samp_cnt_q;
                samp_cnt_q <= 16'h0000;
            end else begin
                if (wr && AVS_ADDRESS == `ADSIO_OFF_STATUS && AVS_WRITEDATA[`ADSIO_STAT_REF])
                    ref_seen_q <= 1'b0;
                if (left_start && samp_cnt_q != 16'hFFFF)
                    samp_cnt_q <= samp_cnt_q + 16'h0001;
            end
            if (wr && AVS_ADDRESS == `ADSIO_OFF_PLL_FRAC) begin
                pll_fraction_setting_q <= AVS_WRITEDATA[15:0];
            end else if (ref_event & comp_on) begin
                PLL_UPDATE <= samp_cnt_q != expect_cnt;
                if (samp_cnt_q < expect_cnt)
                    pll_fraction_setting_q <= pll_fraction_setting_q + `ADSIO_FRAC_STEP;
                else if (samp_cnt_q > expect_cnt)
                    pll_fraction_setting_q <= pll_fraction_setting_q - `ADSIO_FRAC_STEP;
            end
        end
    end

endmodule

`default_nettype wire
